// ==== osd_pkg.sv ====
// Contract
// - Floating select pin picks I2C; a driven select pin picks SPI.
// - I2C transfers start with the slave address; only ours is accepted.
// - Packets continue as row-column-data, column-data, or data-only repeats.
// - Expected address byte: bit 7 set is row, clear is column.
// - Row byte bit 5 picks plane; row in bits 3:0 or 4:0.
// - Column byte bit 6 picks data-only format; column in bits 4:0.
// - Plane 0 (not attribute): column bit 5 is font bit 8, data byte low bits.
// - Data-only format keeps the last font top bit for every byte.
// - Data-only format advances the write location after each data byte.
// - Formats a and b may interchange; data-only format is never left.
// - RAM writes are committed only in display timing write slots.
// - Display cells span rows 0-14, columns 0-29.
package osd_pkg;

    localparam int          BYTE_W          = 8;
    localparam logic [3:0]  BYTE_LAST_BIT   = 4'h7;
    localparam logic [3:0]  BYTE_BITS       = 4'h8;
    localparam int          ROW_FLAG_BIT    = 7;
    localparam int          PLANE_BIT       = 5;
    localparam int          FMT_C_BIT       = 6;
    localparam int          FONT_TOP_BIT    = 5;
    localparam int          ROW_W           = 5;
    localparam int          COL_W           = 5;
    localparam int          CODE_W          = 9;
    localparam logic [7:0]  SLAVE_ADDR_DEF  = 8'h7a;
    localparam logic [4:0]  LAST_COL        = 5'h1f;
    localparam logic [4:0]  LAST_DISP_ROW   = 5'h0e;
    localparam logic [4:0]  LAST_DISP_COL   = 5'h1d;

    typedef enum logic [2:0] {
        P_ROW    = 3'b000,
        P_COL    = 3'b001,
        P_DATA   = 3'b010,
        P_ADDR   = 3'b011,
        P_STREAM = 3'b100
    } parse_e;

endpackage

// ==== osd_serial_write_parser.sv ====
`timescale 1ns/1ps
module osd_serial_write_parser #(
    parameter logic [7:0] SLAVE_ADDR = osd_pkg::SLAVE_ADDR_DEF
) (
    input  wire logic                       clock,
    input  wire logic                       reset_n,
    input  wire logic                       serial_clock,
    input  wire logic                       serial_select_pin,
    input  wire logic                       serial_select_pin_floating,
    input  wire logic                       sda_in,
    output logic                            sda_out,
    output logic                            sda_oe,
    input  wire logic                       display_write_slot,
    output logic                            ram_we,
    output logic                            ram_plane,
    output logic [osd_pkg::ROW_W-1:0]       ram_row,
    output logic [osd_pkg::COL_W-1:0]       ram_col,
    output logic [osd_pkg::CODE_W-1:0]      ram_data,
    output logic                            ram_display_cell,
    output logic                            write_pending,
    output logic                            i2c_mode
);
    import osd_pkg::*;

    if (SLAVE_ADDR[0] != 1'b0) begin : g_bad_addr
        $error("SLAVE_ADDR must be a write address");
    end

    if (CODE_W != BYTE_W + 1) begin : g_bad_code
        $error("Font code must be one bit wider than a byte");
    end

    // Link side: SPI shifter on the serial clock
    typedef struct packed {
        logic [3:0]        bits;
        logic [BYTE_W-1:0] shift;
        logic              first;
    } spi_frame_s;

    // Hand-over word; survives select so the core never sees a false event
    typedef struct packed {
        logic [BYTE_W-1:0] hold;
        logic              hold_first;
        logic              toggle;
    } spi_out_s;

    spi_frame_s frame_r;
    spi_frame_s frame_nxt;
    spi_out_s   spi_r;
    spi_out_s   spi_nxt;
    logic       spi_clear;

    // Select high ends the frame without needing a further clock edge
    assign spi_clear = serial_select_pin | serial_select_pin_floating | ~reset_n;

    always_comb begin
        frame_nxt = frame_r;
        spi_nxt = spi_r;
        frame_nxt.shift = {frame_r.shift[BYTE_W-2:0], sda_in};
        frame_nxt.bits = frame_r.bits + 4'h1;
        if (frame_r.bits == BYTE_LAST_BIT) begin
            frame_nxt.bits = 4'h0;
            frame_nxt.first = 1'b0;
            spi_nxt.hold = {frame_r.shift[BYTE_W-2:0], sda_in};
            spi_nxt.hold_first = frame_r.first;
            spi_nxt.toggle = ~spi_r.toggle;
        end
    end

    always_ff @(posedge serial_clock or posedge spi_clear) begin
        if (spi_clear) begin
            frame_r.bits <= 4'h0;
            frame_r.shift <= '0;
            frame_r.first <= 1'b1;
        end else begin
            frame_r <= frame_nxt;
        end
    end

    // Hold stays put for a whole byte time, so the core reads it
    // directly once the synchronised toggle has moved
    always_ff @(posedge serial_clock or negedge reset_n) begin
        if (!reset_n) begin
            spi_r <= '0;
        end else if (!spi_clear) begin
            spi_r <= spi_nxt;
        end
    end

    // Core side
    typedef struct packed {
        logic [1:0]        flt_s;
        logic [2:0]        scl_s;
        logic [2:0]        sda_s;
        logic [2:0]        tog_s;
        logic              i2c_active;
        logic              i2c_addr_phase;
        logic              i2c_ack_pend;
        logic              i2c_ack_phase;
        logic              i2c_start;
        logic [3:0]        i2c_bits;
        logic [BYTE_W-1:0] i2c_shift;
        logic              sda_oe;
        parse_e            pstate;
        logic              plane;
        logic              fmt_c;
        logic              font_top;
        logic [ROW_W-1:0]  row;
        logic [COL_W-1:0]  col;
        logic              pend;
        logic              pend_plane;
        logic [ROW_W-1:0]  pend_row;
        logic [COL_W-1:0]  pend_col;
        logic [CODE_W-1:0] pend_data;
        logic              we;
        logic              out_plane;
        logic [ROW_W-1:0]  out_row;
        logic [COL_W-1:0]  out_col;
        logic [CODE_W-1:0] out_data;
        logic              out_cell;
    } core_s;

    core_s r_r;
    core_s r_nxt;

    // Reserved and control cells are written too; the flag tells them apart
    function automatic logic in_display(input logic [ROW_W-1:0] row,
                                        input logic [COL_W-1:0] col);
        in_display = (row <= LAST_DISP_ROW) && (col <= LAST_DISP_COL);
    endfunction

    logic              byte_vld;
    logic              byte_start;
    logic [BYTE_W-1:0] byte_val;
    logic              scl_rise;
    logic              scl_fall;
    logic              i2c_sel;
    logic              do_write;
    logic              do_step;
    logic [BYTE_W-1:0] i2c_byte;

    always_comb begin
        r_nxt = r_r;
        byte_vld = 1'b0;
        byte_start = 1'b0;
        byte_val = '0;
        do_write = 1'b0;
        do_step = 1'b0;

        // Two-stage samplers for every pin the core reads
        r_nxt.flt_s = {r_r.flt_s[0], serial_select_pin_floating};
        r_nxt.scl_s = {r_r.scl_s[1:0], serial_clock};
        r_nxt.sda_s = {r_r.sda_s[1:0], sda_in};
        r_nxt.tog_s = {r_r.tog_s[1:0], spi_r.toggle};
        i2c_sel = r_r.flt_s[1];
        scl_rise = r_r.scl_s[1] & ~r_r.scl_s[2];
        scl_fall = ~r_r.scl_s[1] & r_r.scl_s[2];
        i2c_byte = {r_r.i2c_shift[BYTE_W-2:0], r_r.sda_s[1]};

        if (!i2c_sel) begin
            r_nxt.i2c_active = 1'b0;
            r_nxt.sda_oe = 1'b0;
            if (r_r.tog_s[2] != r_r.tog_s[1]) begin
                byte_vld = 1'b1;
                byte_val = spi_r.hold;
                byte_start = spi_r.hold_first;
            end
        end else if (r_r.scl_s[1] && r_r.scl_s[2] && (r_r.sda_s[1] != r_r.sda_s[2])) begin
            // Start when data falls under a high clock, stop when it rises
            r_nxt.i2c_active = ~r_r.sda_s[1];
            r_nxt.i2c_addr_phase = 1'b1;
            r_nxt.i2c_start = 1'b1;
            r_nxt.i2c_bits = 4'h0;
            r_nxt.i2c_ack_pend = 1'b0;
            r_nxt.i2c_ack_phase = 1'b0;
            r_nxt.sda_oe = 1'b0;
        end else if (r_r.i2c_active && scl_rise && !r_r.i2c_ack_phase) begin
            r_nxt.i2c_shift = i2c_byte;
            r_nxt.i2c_bits = r_r.i2c_bits + 4'h1;
            if (r_r.i2c_bits == BYTE_LAST_BIT) begin
                if (r_r.i2c_addr_phase) begin
                    r_nxt.i2c_addr_phase = 1'b0;
                    r_nxt.i2c_ack_pend = (i2c_byte == SLAVE_ADDR);
                    r_nxt.i2c_active = (i2c_byte == SLAVE_ADDR);
                end else begin
                    r_nxt.i2c_ack_pend = 1'b1;
                    byte_vld = 1'b1;
                    byte_val = i2c_byte;
                    byte_start = r_r.i2c_start;
                    r_nxt.i2c_start = 1'b0;
                end
            end
        end else if (r_r.i2c_active && scl_fall) begin
            // Hold the acknowledge low for exactly the ninth clock
            if (r_r.i2c_ack_pend && r_r.i2c_bits == BYTE_BITS) begin
                r_nxt.sda_oe = 1'b1;
                r_nxt.i2c_ack_pend = 1'b0;
                r_nxt.i2c_ack_phase = 1'b1;
                r_nxt.i2c_bits = 4'h0;
            end else if (r_r.i2c_ack_phase) begin
                r_nxt.sda_oe = 1'b0;
                r_nxt.i2c_ack_phase = 1'b0;
            end
        end

        if (byte_vld) begin
            if (byte_start) begin
                r_nxt.pstate = P_ROW;
            end
            case (byte_start ? P_ROW : r_r.pstate)
                P_ROW, P_COL, P_ADDR: begin
                    if (byte_val[ROW_FLAG_BIT]) begin
                        r_nxt.plane = byte_val[PLANE_BIT];
                        r_nxt.row = byte_val[PLANE_BIT] ? byte_val[ROW_W-1:0]
                                                        : {1'b0, byte_val[ROW_W-2:0]};
                        r_nxt.pstate = P_COL;
                    end else if (byte_start || r_r.pstate == P_ROW) begin
                        r_nxt.pstate = P_ROW;
                    end else begin
                        r_nxt.col = byte_val[COL_W-1:0];
                        r_nxt.fmt_c = byte_val[FMT_C_BIT];
                        if (!r_r.plane) begin
                            r_nxt.font_top = byte_val[FONT_TOP_BIT];
                        end
                        r_nxt.pstate = P_DATA;
                    end
                end
                P_DATA: begin
                    do_write = 1'b1;
                    do_step = r_r.fmt_c;
                    r_nxt.pstate = r_r.fmt_c ? P_STREAM : P_ADDR;
                end
                P_STREAM: begin
                    // Never leaves streaming until the transfer ends
                    do_write = 1'b1;
                    do_step = 1'b1;
                end
                default: begin
                    r_nxt.pstate = P_ROW;
                end
            endcase
        end

        if (do_step) begin
            r_nxt.col = r_r.col + 5'h1;
            if (r_r.col == LAST_COL) begin
                r_nxt.col = '0;
                r_nxt.row = r_r.row + 5'h1;
            end
        end

        // One-deep slot: a fresh write replaces one not yet committed
        r_nxt.we = 1'b0;
        if (r_r.pend && display_write_slot) begin
            r_nxt.we = 1'b1;
            r_nxt.pend = 1'b0;
            r_nxt.out_plane = r_r.pend_plane;
            r_nxt.out_row = r_r.pend_row;
            r_nxt.out_col = r_r.pend_col;
            r_nxt.out_data = r_r.pend_data;
            r_nxt.out_cell = in_display(r_r.pend_row, r_r.pend_col);
        end
        if (do_write) begin
            r_nxt.pend = 1'b1;
            r_nxt.pend_plane = r_r.plane;
            r_nxt.pend_row = r_r.row;
            r_nxt.pend_col = r_r.col;
            r_nxt.pend_data = {r_r.plane ? 1'b0 : r_r.font_top, byte_val};
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            r_r <= '0;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe = r_r.sda_oe;
    assign ram_we = r_r.we;
    assign ram_plane = r_r.out_plane;
    assign ram_row = r_r.out_row;
    assign ram_col = r_r.out_col;
    assign ram_data = r_r.out_data;
    assign ram_display_cell = r_r.out_cell;
    assign write_pending = r_r.pend;
    assign i2c_mode = r_r.flt_s[1];

endmodule

// ==== osd_chk.sv ====
`timescale 1ns/1ps
module osd_chk
    import osd_pkg::*;
(
    input wire logic                   clock,
    input wire logic                   reset_n,
    input wire logic                   display_write_slot,
    input wire logic                   ram_we,
    input wire logic                   ram_plane,
    input wire logic [osd_pkg::ROW_W-1:0]  ram_row,
    input wire logic [osd_pkg::COL_W-1:0]  ram_col,
    input wire logic [osd_pkg::CODE_W-1:0] ram_data,
    input wire logic                   ram_display_cell,
    input wire logic                   write_pending,
    input wire logic                   i2c_mode,
    input wire logic                   sda_out,
    input wire logic                   sda_oe
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    a_commit_next: assert property (
        write_pending && display_write_slot |=> ram_we) else $error("pending write not committed");
    a_we_has_cause: assert property (
        ram_we |-> $past(write_pending && display_write_slot)) else $error("write outside a slot");
    a_wait_for_slot: assert property (
        write_pending && !display_write_slot |=> write_pending && !ram_we)
        else $error("pending write lost or early");
    a_we_one_pulse: assert property (ram_we |=> !ram_we) else $error("write strobe too long");
    a_hold_location: assert property (
        !ram_we |-> $stable({ram_plane, ram_row, ram_col, ram_data, ram_display_cell}))
        else $error("write location moved without a write");
    a_display_cell: assert property (
        ram_we |-> ram_display_cell == (ram_row <= LAST_DISP_ROW && ram_col <= LAST_DISP_COL))
        else $error("display cell flag wrong");
    a_attr_top_clear: assert property (
        ram_we && ram_plane |-> !ram_data[CODE_W-1]) else $error("attribute code top bit set");
    a_spi_quiet_sda: assert property (!i2c_mode [*3] |-> !sda_oe) else $error("SDA driven in SPI");
    a_sda_low_only: assert property (sda_out == 1'b0) else $error("SDA driven high");
endmodule
bind osd_serial_write_parser osd_chk chk_i (.clock, .reset_n, .display_write_slot, .ram_we,
    .ram_plane, .ram_row, .ram_col, .ram_data, .ram_display_cell, .write_pending, .i2c_mode,
    .sda_out, .sda_oe);

// ==== osd_host.sv ====
`timescale 1ns/1ps
module osd_host (
    output logic serial_clock,
    output logic serial_select_pin,
    output logic sda,
    input  wire logic sda_line
);
    // Pull-ups hold idle lines high; clock stands still between frames
    initial begin
        serial_clock = 1'b1;
        serial_select_pin = 1'b1;
        sda = 1'b1;
    end
    task automatic start;
        #13 serial_select_pin = 1'b0;
        #40;
    endtask
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            serial_clock = 1'b0;
            sda = b[i];
            #40 serial_clock = 1'b1;
            #40;
        end
        sda = ~b[0]; // Stale bit never lingers
    endtask
    task automatic stop;
        #40 serial_select_pin = 1'b1;
        sda = 1'b1;
        #200;
    endtask
    // Open-drain bus: data moves while the clock is low, except start and stop, which move it under a high clock
    task automatic i2c_start;
        serial_clock = 1'b0;
        #20 sda = 1'b1;
        #20 serial_clock = 1'b1;
        #20 sda = 1'b0;
        #20;
    endtask
    task automatic i2c_send(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            serial_clock = 1'b0;
            #20 sda = b[i];
            #20 serial_clock = 1'b1;
            #40;
        end
        serial_clock = 1'b0;
        #20 sda = 1'b1;
        #20 serial_clock = 1'b1;
        #20 ack = sda_line;
        #20;
    endtask
    task automatic i2c_stop;
        serial_clock = 1'b0;
        #20 sda = 1'b0;
        #20 serial_clock = 1'b1;
        #20 sda = 1'b1;
        #40;
    endtask
endmodule

// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
    import osd_pkg::*;
    logic              clock = 1'b0;
    logic              reset_n = 1'b0;
    logic              serial_select_pin_floating = 1'b0;
    logic              display_write_slot = 1'b1;
    wire logic         serial_clock;
    wire logic         serial_select_pin;
    wire logic         host_sda;
    logic              sda_out, sda_oe, ram_we, ram_plane, ram_display_cell;
    logic              write_pending, i2c_mode, stall = 1'b0, pl, b8, fc;
    logic              i2c_on = 1'b0, ack;
    logic [ROW_W-1:0]  ram_row, row;
    logic [COL_W-1:0]  ram_col, col;
    logic [CODE_W-1:0] ram_data;
    logic [15:0]       rd = 16'h6f38, lf = 16'h6f38;
    logic [7:0]        r;
    logic [1:0]        st;
    logic [19:0]       expq[$];
    int                n_errors = 0, checks_done = 0;
    wire logic         sda_in = sda_oe ? sda_out : host_sda;

    osd_serial_write_parser dut (.clock, .reset_n, .serial_clock, .serial_select_pin,
        .serial_select_pin_floating, .sda_in, .sda_out, .sda_oe, .display_write_slot, .ram_we,
        .ram_plane, .ram_row, .ram_col, .ram_data, .ram_display_cell, .write_pending, .i2c_mode);
    osd_host host (.serial_clock, .serial_select_pin, .sda(host_sda), .sda_line(sda_in));

    always #5 clock = ~clock;
    function automatic logic [15:0] nxt(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    function automatic logic [7:0] rnd();
        rd = nxt(rd);
        return rd[7:0];
    endfunction
    always @(posedge clock) begin
        #1;
        lf = nxt(lf);
        display_write_slot = !stall && lf[1:0] != 2'b00;
    end
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    always @(negedge clock) begin
        if (ram_we === 1'b1) begin
            chk({ram_plane, ram_row, ram_col, ram_data}, expq.size() ? expq.pop_front() : '1);
        end
    end
    // Expectation first: the design may commit before the host task returns
    task automatic put(input logic [7:0] b);
        if (st == 2'd2) begin
            expq.push_back({pl, row, col, pl ? {1'b0, b} : {b8, b}});
            if (fc) {row, col} = {row, col} + 10'h001;
            st = fc ? 2'd2 : 2'd1;
        end else if (b[7]) begin
            pl = b[5];
            row = b[5] ? b[4:0] : {1'b0, b[3:0]};
            st = 2'd1;
        end else if (st == 2'd1) begin
            col = b[4:0];
            fc = b[6];
            st = 2'd2;
            if (!pl) b8 = b[5];
        end
        if (i2c_on) begin
            host.i2c_send(b, ack);
            chk(20'(ack), 20'h0);
        end else begin
            host.send_byte(b);
        end
    endtask
    task automatic xs;
        st = 2'd0;
        fc = 1'b0;
        host.start;
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #400000;
        n_errors++;
        print_verdict;
    end
    initial begin
        repeat (10) @(posedge clock);
        #1 reset_n = 1'b1;
        repeat (5) @(posedge clock);
        xs;
        put(8'h05);
        put(8'h83); put(8'h25); put(rnd());
        put(8'hb3); put(8'h3e); put(rnd());
        put(8'h07); put(rnd());
        put(8'h8e); put(8'h7f); repeat (3) put(rnd()); put(8'h90);
        host.stop;
        $display("test formats finished");
        xs;
        put(8'h81); put(8'h40); put(rnd()); put(rnd());
        host.stop;
        xs;
        put(8'h11); put(8'h82); put(8'h03); put(rnd());
        host.stop;
        $display("test restart finished");
        xs;
        repeat (6) begin
            r = rnd();
            put({2'b10, r[5:0]}); put({2'b00, r[7:2]}); put(rnd());
        end
        host.stop;
        $display("test random finished");
        stall = 1'b1;
        xs;
        put(8'hbe); put(8'h1c); put(rnd());
        host.stop;
        repeat (100) @(posedge clock);
        #1 chk(20'(write_pending), 20'h1);
        stall = 1'b0;
        $display("test stall finished");
        @(posedge clock) #1 serial_select_pin_floating = 1'b1;
        repeat (5) @(posedge clock);
        #1 chk(20'(i2c_mode), 20'h1);
        i2c_on = 1'b1;
        st = 2'd0;
        fc = 1'b0;
        host.i2c_start;
        host.i2c_send(SLAVE_ADDR_DEF, ack);
        chk(20'(ack), 20'h0);
        put(8'h05);
        put(8'ha4);
        put(8'h0a);
        put(rnd());
        put(8'h0b);
        put(rnd());
        host.i2c_stop;
        host.i2c_start;
        host.i2c_send(8'h7c, ack);
        chk(20'(ack), 20'h1);
        host.i2c_send(8'h83, ack);
        host.i2c_send(8'h01, ack);
        host.i2c_send(rnd(), ack);
        chk(20'(ack), 20'h1);
        host.i2c_stop;
        i2c_on = 1'b0;
        $display("test i2c finished");
        @(posedge clock) #1 serial_select_pin_floating = 1'b0;
        repeat (5) @(posedge clock);
        #1 chk(20'(i2c_mode), 20'h0);
        $display("test mode finished");
        repeat (50) @(posedge clock);
        chk(20'(expq.size()), 20'h0);
        print_verdict;
    end
endmodule
